// file: hdl/imp_sweep_regs.sv
// two-wire register bank with sweep sequencer and result capture
`timescale 1ns/1ps
module imp_sweep_regs
  import imp_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
  input  wire logic        mclk,       // device clock
  input  wire logic        arst_n,     // async reset, low active
  input  wire logic        scl_i,      // bus clock pin
  input  wire logic        sda_i,      // bus data pin level
  output logic             sda_o,      // data pin drive value
  output logic             sda_oe,     // high while pulling data low
  input  wire logic [11:0] adc_data,   // converter sample, signed
  output logic             adc_conv,   // one-cycle sample trigger
  output logic [23:0]      synth_freq, // excitation frequency code
  output logic             synth_run,  // excitation running
  output logic             pwr_down    // power-down mode
);
  localparam int SAMP_DIV = CONV_CYCLES / SAMPLES;

  // settle count after multiplier, reserved code falls back to x1
  function automatic logic [10:0] settle_total(input logic [10:0] s);
    logic [10:0] b;
    b = {2'b00, s[8:0]};
    unique case (s[10:9])
      2'b01:   return b << 1;
      2'b11:   return b << 2;
      default: return b;
    endcase
  endfunction : settle_total

  // pin synchronisers; stage 0 feeds stage 1 only
  logic [2:0]  scl_sy_ff, sda_sy_ff;
  logic [11:0] adc_s1_ff, adc_s2_ff;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
      adc_s1_ff <= 12'h000;
      adc_s2_ff <= 12'h000;
    end else begin
      scl_sy_ff <= {scl_sy_ff[1:0], scl_i};
      sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
      adc_s1_ff <= adc_data;
      adc_s2_ff <= adc_s1_ff;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop, sda_s;
  assign sda_s     = sda_sy_ff[1];
  assign scl_rise  = scl_sy_ff[1] & ~scl_sy_ff[2];
  assign scl_fall  = ~scl_sy_ff[1] & scl_sy_ff[2];
  assign bus_start = scl_sy_ff[1] & scl_sy_ff[2] & ~sda_s & sda_sy_ff[2];
  assign bus_stop  = scl_sy_ff[1] & scl_sy_ff[2] & sda_s & ~sda_sy_ff[2];

  // bus byte engine, open drain: only ever pulls low
  imp_bus_t   ist_ff;
  logic [3:0] bitc_ff;
  logic [7:0] shreg_ff, txsh_ff, rd_data;
  logic       rw_ff, drv_ff, wr_p, rd_load;
  assign wr_p    = scl_fall & (bitc_ff == 4'h8) & (ist_ff == I_WR);
  assign rd_load = scl_fall & (bitc_ff == 4'h9) &
                   ((ist_ff == I_RD) | ((ist_ff == I_ADDR) & rw_ff));
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ist_ff   <= I_IDLE;
      bitc_ff  <= 4'h0;
      shreg_ff <= 8'h00;
      txsh_ff  <= 8'h00;
      rw_ff    <= 1'b0;
      drv_ff   <= 1'b0;
    end else if (bus_start) begin
      ist_ff  <= I_ADDR;
      bitc_ff <= 4'h0;
      drv_ff  <= 1'b0;
    end else if (bus_stop) begin
      ist_ff <= I_IDLE;
      drv_ff <= 1'b0;
    end else if (ist_ff != I_IDLE) begin
      if (scl_rise) begin
        if (bitc_ff < 4'h8) begin
          shreg_ff <= {shreg_ff[6:0], sda_s};
          bitc_ff  <= bitc_ff + 4'h1;
        end else if (bitc_ff == 4'h8) begin
          bitc_ff <= 4'h9;
          // master nack ends the read
          if (ist_ff == I_RD && sda_s) ist_ff <= I_IDLE;
        end
      end
      if (scl_fall) begin
        if (bitc_ff == 4'h8) begin
          unique case (ist_ff)
            I_ADDR: begin
              rw_ff <= shreg_ff[0];
              if (shreg_ff[7:1] == SLAVE_ADDR) drv_ff <= 1'b1;
              else ist_ff <= I_IDLE;
            end
            I_WR:    drv_ff <= 1'b1;
            default: drv_ff <= 1'b0;
          endcase
        end else if (bitc_ff == 4'h9) begin
          bitc_ff <= 4'h0;
          if (ist_ff == I_ADDR) ist_ff <= rw_ff ? I_RD : I_WR;
          if (rd_load) begin
            txsh_ff <= rd_data;
            drv_ff  <= ~rd_data[7];
          end else begin
            drv_ff <= 1'b0;
          end
        end else if (ist_ff == I_RD && bitc_ff != 4'h0) begin
          txsh_ff <= {txsh_ff[6:0], 1'b0};
          drv_ff  <= ~txsh_ff[6];
        end
      end
    end
  end
  assign sda_o  = 1'b0;
  assign sda_oe = drv_ff;

  // pointer and write-mode tracking
  imp_wmode_t wmode_ff;
  logic [7:0] ptr_ff;
  logic       blk_rd_ff, reg_wr;
  assign reg_wr = wr_p & (wmode_ff == W_DATA);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wmode_ff  <= W_CMD;
      ptr_ff    <= 8'h00;
      blk_rd_ff <= 1'b0;
    end else if (bus_start) begin
      wmode_ff <= W_CMD;
    end else if (wr_p) begin
      unique case (wmode_ff)
        W_CMD: begin
          if (shreg_ff == CMD_PTR) begin
            wmode_ff <= W_PTR;
          end else if (shreg_ff == CMD_BLK_WR ||
                       shreg_ff == CMD_BLK_RD) begin
            blk_rd_ff <= (shreg_ff == CMD_BLK_RD);
            wmode_ff  <= W_CNT;
          end else begin
            ptr_ff    <= shreg_ff;
            blk_rd_ff <= 1'b0;
            wmode_ff  <= W_DATA;
          end
        end
        W_PTR: begin
          ptr_ff    <= shreg_ff;
          blk_rd_ff <= 1'b0;
          wmode_ff  <= W_DATA;
        end
        W_CNT:  wmode_ff <= W_DATA; // byte count is not enforced
        W_DATA: ptr_ff <= ptr_ff + 8'h01;
      endcase
    end else if (rd_load && blk_rd_ff) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  // sweep parameters: deliberately no reset, survive everything
  logic [23:0] start_ff, step_ff;
  logic [8:0]  npts_ff;
  logic [10:0] settle_ff;
  always_ff @(posedge mclk) begin
    if (reg_wr) begin
      unique case (ptr_ff)
        ADR_START_H: start_ff[23:16] <= shreg_ff;
        ADR_START_M: start_ff[15:8]  <= shreg_ff;
        ADR_START_L: start_ff[7:0]   <= shreg_ff;
        ADR_STEP_H:  step_ff[23:16]  <= shreg_ff;
        ADR_STEP_M:  step_ff[15:8]   <= shreg_ff;
        ADR_STEP_L:  step_ff[7:0]    <= shreg_ff;
        ADR_NPTS_H:  npts_ff[8]      <= shreg_ff[0];
        ADR_NPTS_L:  npts_ff[7:0]    <= shreg_ff;
        ADR_SET_H:   settle_ff[10:8] <= shreg_ff[2:0];
        ADR_SET_L:   settle_ff[7:0]  <= shreg_ff;
        default: ;
      endcase
    end
  end

  // control register and command decode
  logic [7:0] ctrl_hi_ff, ctrl_lo_ff;
  logic       cmd_p, go_init, go_sweep, go_inc, go_rep, go_pd, go_sb;
  logic       rst_cmd, cmd_any;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_hi_ff <= CTRL_HI_RST;
      ctrl_lo_ff <= CTRL_LO_RST;
    end else if (reg_wr && ptr_ff == ADR_CTRL_HI) begin
      ctrl_hi_ff <= shreg_ff;
    end else if (reg_wr && ptr_ff == ADR_CTRL_LO) begin
      ctrl_lo_ff <= shreg_ff;
    end
  end
  assign cmd_p    = reg_wr & (ptr_ff == ADR_CTRL_HI);
  assign go_init  = cmd_p & (shreg_ff[7:4] == C_INIT);
  assign go_sweep = cmd_p & (shreg_ff[7:4] == C_SWEEP);
  assign go_inc   = cmd_p & (shreg_ff[7:4] == C_INC);
  assign go_rep   = cmd_p & (shreg_ff[7:4] == C_REP);
  assign go_pd    = cmd_p & (shreg_ff[7:4] == C_PDOWN);
  assign go_sb    = cmd_p & (shreg_ff[7:4] == C_STBY);
  assign rst_cmd  = reg_wr & (ptr_ff == ADR_CTRL_LO) &
                    shreg_ff[CTRL_RST_BIT];
  assign cmd_any  = go_init | go_sweep | go_inc | go_rep | go_pd | go_sb |
                    rst_cmd;

  // excitation phase accumulator, one step per synth tick
  imp_seq_t           seq_ff;
  logic [3:0]         div_ff;
  logic [PHASE_W-1:0] acc_ff;
  logic [PHASE_W:0]   acc_sum;
  logic               tick, cyc_p;
  logic [23:0]        freq_ff;
  assign tick    = (div_ff == 4'(SYNTH_DIV - 1));
  assign acc_sum = {1'b0, acc_ff} + {4'h0, freq_ff};
  assign cyc_p   = tick & acc_sum[PHASE_W]; // one excitation cycle done
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= 4'h0;
      acc_ff <= '0;
    end else if (seq_ff == S_IDLE) begin
      div_ff <= 4'h0;
      acc_ff <= '0;
    end else begin
      div_ff <= div_ff + 4'h1;
      if (tick) acc_ff <= acc_sum[PHASE_W-1:0];
    end
  end

  // sweep sequencer: settle, then collect a fixed sample burst
  logic [8:0]  idx_ff;
  logic [10:0] setc_ff;
  logic [16:0] tdiv_ff;
  logic [10:0] smp_ff;
  logic        samp_tick, done_p, conv_ff;
  logic signed [21:0] re_acc_ff, im_acc_ff, nxt_re, nxt_im, sx;
  assign samp_tick = (seq_ff == S_MEAS) & (tdiv_ff == 17'(SAMP_DIV - 1));
  assign done_p    = samp_tick & ~cmd_any &
                     (smp_ff == 11'(SAMPLES - 1));
  assign sx        = 22'(signed'(adc_s2_ff));
  // square-wave correlation against in-phase and quadrature signs
  assign nxt_re    = acc_ff[PHASE_W-1] ? re_acc_ff - sx : re_acc_ff + sx;
  assign nxt_im    = (acc_ff[PHASE_W-1] ^ acc_ff[PHASE_W-2]) ?
                     im_acc_ff + sx : im_acc_ff - sx;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      seq_ff    <= S_IDLE;
      freq_ff   <= 24'h000000;
      idx_ff    <= 9'h000;
      setc_ff   <= 11'h000;
      tdiv_ff   <= 17'h00000;
      smp_ff    <= 11'h000;
      re_acc_ff <= '0;
      im_acc_ff <= '0;
      conv_ff   <= 1'b0;
    end else begin
      conv_ff <= samp_tick & ~cmd_any;
      if (rst_cmd || go_pd || go_sb) begin
        seq_ff <= S_IDLE;
      end else if (go_init) begin
        seq_ff  <= S_INIT;
        freq_ff <= start_ff;
        idx_ff  <= 9'h000;
      end else if (go_sweep || go_inc || go_rep) begin
        seq_ff  <= S_SETTLE;
        setc_ff <= settle_total(settle_ff);
        if (go_inc && idx_ff < npts_ff) begin
          freq_ff <= freq_ff + step_ff;
          idx_ff  <= idx_ff + 9'h001;
        end
      end else begin
        unique case (seq_ff)
          S_SETTLE: begin
            if (setc_ff == 11'h000) begin
              seq_ff    <= S_MEAS;
              tdiv_ff   <= 17'h00000;
              smp_ff    <= 11'h000;
              re_acc_ff <= '0;
              im_acc_ff <= '0;
            end else if (cyc_p) begin
              setc_ff <= setc_ff - 11'h001;
            end
          end
          S_MEAS: begin
            if (samp_tick) begin
              tdiv_ff   <= 17'h00000;
              smp_ff    <= smp_ff + 11'h001;
              re_acc_ff <= nxt_re;
              im_acc_ff <= nxt_im;
              if (done_p) seq_ff <= S_HOLD;
            end else begin
              tdiv_ff <= tdiv_ff + 17'h00001;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // results: no reset, overwritten only when a point completes
  logic [15:0] re_ff, im_ff;
  always_ff @(posedge mclk) begin
    if (done_p) begin
      re_ff <= nxt_re[21:6];
      im_ff <= nxt_im[21:6];
    end
  end

  // status flags; completion set wins over a clear
  logic valid_ff, cmpl_ff, last_pt;
  assign last_pt = (idx_ff == npts_ff);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      valid_ff <= 1'b0;
      cmpl_ff  <= 1'b0;
    end else begin
      if (done_p) valid_ff <= 1'b1;
      else if (go_sweep || go_inc || go_rep || rst_cmd) valid_ff <= 1'b0;
      if (done_p && last_pt) cmpl_ff <= 1'b1;
      else if (go_sweep || rst_cmd) cmpl_ff <= 1'b0;
    end
  end

  // power mode follows the last power-down, standby or init command
  logic pd_ff;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) pd_ff <= 1'b1;
    else if (go_pd) pd_ff <= 1'b1;
    else if (go_sb || go_init) pd_ff <= 1'b0;
  end

  // read mux; unmapped and ignored bits read zero
  always_comb begin
    unique case (ptr_ff)
      ADR_CTRL_HI: rd_data = ctrl_hi_ff;
      ADR_CTRL_LO: rd_data = ctrl_lo_ff;
      ADR_START_H: rd_data = start_ff[23:16];
      ADR_START_M: rd_data = start_ff[15:8];
      ADR_START_L: rd_data = start_ff[7:0];
      ADR_STEP_H:  rd_data = step_ff[23:16];
      ADR_STEP_M:  rd_data = step_ff[15:8];
      ADR_STEP_L:  rd_data = step_ff[7:0];
      ADR_NPTS_H:  rd_data = {7'h00, npts_ff[8]};
      ADR_NPTS_L:  rd_data = npts_ff[7:0];
      ADR_SET_H:   rd_data = {5'h00, settle_ff[10:8]};
      ADR_SET_L:   rd_data = settle_ff[7:0];
      ADR_STATUS:  rd_data = {5'h00, cmpl_ff, valid_ff, 1'b0};
      ADR_RE_H:    rd_data = re_ff[15:8];
      ADR_RE_L:    rd_data = re_ff[7:0];
      ADR_IM_H:    rd_data = im_ff[15:8];
      ADR_IM_L:    rd_data = im_ff[7:0];
      default:     rd_data = 8'h00;
    endcase
  end

  assign adc_conv   = conv_ff;
  assign synth_freq = freq_ff;
  assign synth_run  = ~seq_ff[0];
  assign pwr_down   = pd_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence clr_cmd_s; (go_sweep || go_inc || go_rep || rst_cmd); endsequence
  valid_clear_a: assert property (clr_cmd_s |=> !valid_ff)
    else $error("valid flag not cleared by command");
  valid_set_a: assert property (done_p |=>
      valid_ff && seq_ff == S_HOLD)
    else $error("valid flag not set at point end");
  sweep_done_a: assert property (done_p && last_pt |=> cmpl_ff)
    else $error("sweep complete flag missing");
  sweep_clear_a: assert property ((go_sweep || rst_cmd) |=>
      !cmpl_ff)
    else $error("sweep complete not cleared");
  settle_load_a: assert property ((go_rep && !rst_cmd) |=>
      setc_ff == settle_total(settle_ff) && setc_ff <= 11'h7fc)
    else $error("settle count load wrong");
  step_add_a: assert property (go_inc && idx_ff < npts_ff |=>
      freq_ff == $past(freq_ff) + step_ff)
    else $error("frequency step not applied");
  keep_params_a: assert property (rst_cmd |=>
      $stable(step_ff) && $stable(npts_ff) && $stable(settle_ff))
    else $error("parameters changed by reset");
  result_hold_a: assert property (!done_p |=> $stable(re_ff) &&
      $stable(im_ff))
    else $error("result changed without completion");
  status_rsvd_a: assert property (ptr_ff == ADR_STATUS |->
      rd_data[7:3] == 5'h00 && !rd_data[0])
    else $error("reserved status bits set");
  meas_len_a: assert property ($rose(seq_ff == S_HOLD) |->
      smp_ff == 11'h400)
    else $error("wrong sample count");
endmodule : imp_sweep_regs

// file: hdl/imp_pkg.sv
// constants, codes and state types of the sweep register block
package imp_pkg;
  localparam logic [6:0] SLAVE_ADDR  = 7'h0d;
  localparam logic [7:0] ADR_CTRL_HI = 8'h80;
  localparam logic [7:0] ADR_CTRL_LO = 8'h81;
  localparam logic [7:0] ADR_START_H = 8'h82;
  localparam logic [7:0] ADR_START_M = 8'h83;
  localparam logic [7:0] ADR_START_L = 8'h84;
  localparam logic [7:0] ADR_STEP_H  = 8'h85;
  localparam logic [7:0] ADR_STEP_M  = 8'h86;
  localparam logic [7:0] ADR_STEP_L  = 8'h87;
  localparam logic [7:0] ADR_NPTS_H  = 8'h88;
  localparam logic [7:0] ADR_NPTS_L  = 8'h89;
  localparam logic [7:0] ADR_SET_H   = 8'h8a;
  localparam logic [7:0] ADR_SET_L   = 8'h8b;
  localparam logic [7:0] ADR_STATUS  = 8'h8f;
  localparam logic [7:0] ADR_RE_H    = 8'h94;
  localparam logic [7:0] ADR_RE_L    = 8'h95;
  localparam logic [7:0] ADR_IM_H    = 8'h96;
  localparam logic [7:0] ADR_IM_L    = 8'h97;
  localparam logic [7:0] CMD_PTR     = 8'hb0;
  localparam logic [7:0] CMD_BLK_WR  = 8'ha0;
  localparam logic [7:0] CMD_BLK_RD  = 8'ha1;
  localparam logic [3:0] C_INIT = 4'h1;
  localparam logic [3:0] C_SWEEP = 4'h2;
  localparam logic [3:0] C_INC = 4'h3;
  localparam logic [3:0] C_REP = 4'h4;
  localparam logic [3:0] C_PDOWN = 4'ha;
  localparam logic [3:0] C_STBY = 4'hb;
  localparam int         CTRL_RST_BIT = 4;
  localparam logic [7:0] CTRL_HI_RST = 8'ha0;
  localparam logic [7:0] CTRL_LO_RST = 8'h08;
  localparam int         SYNTH_DIV = 16;
  localparam int         PHASE_W = 27;
  localparam int         SAMPLES = 1024;
  localparam int         CONV_TIME_US = 1000;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         CONV_CYCLES_DEF = CONV_TIME_US * 1000 / CLK_PERIOD_NS;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_INIT = 5'h02, S_SETTLE = 5'h04,
    S_MEAS = 5'h08, S_HOLD = 5'h10
  } imp_seq_t;
  typedef enum logic [3:0] {
    I_IDLE = 4'h1, I_ADDR = 4'h2, I_WR = 4'h4, I_RD = 4'h8
  } imp_bus_t;
  typedef enum logic [3:0] {
    W_CMD = 4'h1, W_PTR = 4'h2, W_CNT = 4'h4, W_DATA = 4'h8
  } imp_wmode_t;
endpackage : imp_pkg

// file: sim/imp_bus_master.sv
// two-wire bus master model for the sweep register bench
`timescale 1ns/1ps
module imp_bus_master (
  input  wire logic mclk,  // device clock
  input  wire logic sda_w, // resolved data wire
  output logic      scl,   // bus clock, idles high
  output logic      sda_m  // master data, 1 releases the wire
);
  // bus released and clock still between frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // steps of one mclk, an eighth of the 80 ns bus clock
  task automatic q(input int n);
    repeat (n) @(posedge mclk);
  endtask : q
  // data falls while the clock is high
  task automatic start;
    sda_m <= 1'b1;
    q(2);
    scl <= 1'b1;
    q(4);
    sda_m <= 1'b0;
    q(4);
    scl <= 1'b0;
    q(2);
  endtask : start
  // data rises while the clock is high, then the bus stands still
  task automatic stop;
    sda_m <= 1'b0;
    q(2);
    scl <= 1'b1;
    q(4);
    sda_m <= 1'b1;
    q(4);
  endtask : stop
  // data changes only while the clock is low, sampled late in the high
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    q(2);
    scl <= 1'b1;
    q(4);
    r = sda_w;
    scl <= 1'b0;
    q(2);
  endtask : bit_x
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(mack, a);
    ack = ~a;
  endtask : xfer
endmodule : imp_bus_master

// file: sim/imp_sweep_regs_tb.sv
// self-checking bench for the sweep register block
`timescale 1ns/1ps
module imp_sweep_regs_tb;
  import imp_pkg::*;
  localparam int CONV = 2048; // short conversion keeps the run brief
  localparam int EXC  = 256;  // mclk per excitation cycle at 0x800000
  localparam logic [23:0] START = 24'h800000;
  localparam logic [23:0] STEP  =
    24'((10 * (2 ** 27)) / (16000000 / SYNTH_DIV));
  logic        mclk        = 1'b0;    // device clock
  logic        arst_n      = 1'b0;    // reset, low active
  logic [11:0] adc_data    = 12'h000; // converter sample pattern
  logic        scl;                   // bus clock from master
  logic        sda_m;                 // master data drive
  logic        sda_o;                 // device drive value
  logic        sda_oe;                // device pulls data low
  logic        adc_conv;              // sample trigger
  logic [23:0] synth_freq;            // frequency code
  logic        synth_run;             // excitation running
  logic        pwr_down;              // power-down mode
  wire         sda_w;                 // resolved data wire
  int          err_total   = 0;
  int          check_count = 0;
  int          conv_cnt    = 0;
  // pull-up wire, either party may pull it low
  assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
  imp_sweep_regs #(.CONV_CYCLES(CONV)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .adc_data(adc_data),
    .adc_conv(adc_conv), .synth_freq(synth_freq),
    .synth_run(synth_run), .pwr_down(pwr_down));
  imp_bus_master i_master (
    .mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  always #5 mclk = ~mclk;
  // moving sample pattern so results are not trivially zero
  always @(posedge mclk) adc_data <= adc_data + 12'h0b5;
  // count sample triggers for per-point totals and settle spans
  always @(posedge mclk) if (adc_conv === 1'b1) conv_cnt <= conv_cnt + 1;
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [23:0] seen, exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, d);
    logic [7:0] r;
    logic       k;
    i_master.start();
    i_master.xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, k);
    chk(24'(k), 24'h1, "address acknowledged");
    i_master.xfer(a, 1'b1, r, k);
    i_master.xfer(d, 1'b1, r, k);
    chk(24'(k), 24'h1, "data acknowledged");
    i_master.stop();
  endtask : wr_reg
  // pointer set, then a single byte read closed by a nack
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    logic       k;
    wr_reg(CMD_PTR, a);
    i_master.start();
    i_master.xfer({SLAVE_ADDR, 1'b1}, 1'b1, r, k);
    chk(24'(k), 24'h1, "read address acknowledged");
    i_master.xfer(8'hff, 1'b1, d, k);
    i_master.stop();
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, exp, input string msg);
    logic [7:0] v;
    rd_reg(a, v);
    chk(24'(v), 24'(exp), msg);
  endtask : rd_chk
  task automatic cmd(input logic [3:0] c);
    wr_reg(ADR_CTRL_HI, {c, 4'h0});
  endtask : cmd
  task automatic wait_done(input int c0);
    int n = 0;
    while (conv_cnt - c0 < SAMPLES && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    repeat (50) @(posedge mclk);
    chk(24'(conv_cnt - c0), 24'(SAMPLES), "samples per point");
  endtask : wait_done
  task automatic t_reset_state;
    logic [7:0] r;
    logic       k;
    chk(24'(pwr_down), 24'h1, "power-down after reset");
    chk(24'(sda_oe), 24'h0, "data line released");
    rd_chk(ADR_STATUS, 8'h00, "status after reset");
    i_master.start();
    i_master.xfer({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, r, k);
    i_master.stop();
    chk(24'(k), 24'h0, "foreign address ignored");
  endtask : t_reset_state
  task automatic t_regs;
    wr_reg(ADR_STEP_H, STEP[23:16]);
    wr_reg(ADR_STEP_M, STEP[15:8]);
    wr_reg(ADR_STEP_L, STEP[7:0]);
    rd_chk(ADR_STEP_H, STEP[23:16], "step high");
    rd_chk(ADR_STEP_M, STEP[15:8], "step mid");
    rd_chk(ADR_STEP_L, STEP[7:0], "step low");
    wr_reg(ADR_NPTS_H, 8'hff);
    rd_chk(ADR_NPTS_H, 8'h01, "count upper bits");
    wr_reg(ADR_SET_H, 8'hff);
    rd_chk(ADR_SET_H, 8'h07, "settle upper bits");
    wr_reg(ADR_STATUS, 8'hff);
    rd_chk(ADR_STATUS, 8'h00, "status read-only");
    rd_chk(8'h90, 8'h00, "unmapped reads zero");
  endtask : t_regs
  // one increment: sweep point 0, increment to point 1, repeat, reset
  task automatic t_sweep;
    logic [7:0] re_h;
    logic [7:0] im_l;
    int         c0;
    wr_reg(ADR_START_H, START[23:16]);
    wr_reg(ADR_START_M, START[15:8]);
    wr_reg(ADR_START_L, START[7:0]);
    wr_reg(ADR_NPTS_H, 8'h00);
    wr_reg(ADR_NPTS_L, 8'h01);
    wr_reg(ADR_SET_H, 8'h00);
    wr_reg(ADR_SET_L, 8'h02);
    cmd(C_INIT);
    chk(24'(pwr_down), 24'h0, "init leaves power-down");
    chk(24'(synth_run), 24'h1, "excitation runs");
    cmd(C_SWEEP);
    c0 = conv_cnt;
    chk(synth_freq, START, "sweep at start code");
    rd_chk(ADR_STATUS, 8'h00, "flags clear at sweep");
    wait_done(c0);
    rd_chk(ADR_STATUS, 8'h02, "point valid");
    cmd(C_INC);
    c0 = conv_cnt;
    chk(synth_freq, START + STEP, "stepped code");
    rd_chk(ADR_STATUS, 8'h00, "valid clear at increment");
    wait_done(c0);
    rd_chk(ADR_STATUS, 8'h06, "last point complete");
    cmd(C_INC);
    chk(synth_freq, START + STEP, "no step past count");
    cmd(C_REP);
    c0 = conv_cnt;
    chk(synth_freq, START + STEP, "repeat keeps code");
    rd_chk(ADR_STATUS, 8'h04, "repeat keeps sweep flag");
    wait_done(c0);
    rd_reg(ADR_RE_H, re_h);
    rd_reg(ADR_IM_L, im_l);
    wr_reg(ADR_CTRL_LO, CTRL_LO_RST | 8'(1 << CTRL_RST_BIT));
    chk(24'(synth_run), 24'h0, "reset goes idle");
    rd_chk(ADR_STATUS, 8'h00, "reset clears flags");
    rd_chk(ADR_RE_H, re_h, "real kept");
    rd_chk(ADR_IM_L, im_l, "imag kept");
    rd_chk(ADR_STEP_M, STEP[15:8], "step kept");
    rd_chk(ADR_NPTS_L, 8'h01, "count kept");
    rd_chk(ADR_SET_L, 8'h02, "settle kept");
  endtask : t_sweep
  // settle count 2 under each multiplier code, repeat restarts settle
  task automatic t_settle;
    int   nx[4] = '{2, 4, 2, 8};
    int   c0;
    int   n;
    logic ok;
    cmd(C_INIT);
    chk(synth_freq, START, "init reloads start");
    cmd(C_SWEEP);
    wait_done(conv_cnt);
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADR_SET_H, 8'(i * 2));
      cmd(C_REP);
      c0 = conv_cnt;
      n = 0;
      while (conv_cnt == c0 && n < 4000) begin
        @(posedge mclk);
        n++;
      end
      ok = n >= (nx[i] - 1) * EXC - 20 && n <= nx[i] * EXC + 40;
      chk(24'(ok), 24'h1, "settle span");
      wait_done(c0);
    end
    // finish the sweep again, then a new sweep must drop the flag
    cmd(C_INC);
    wait_done(conv_cnt);
    rd_chk(ADR_STATUS, 8'h06, "second sweep complete");
    cmd(C_SWEEP);
    rd_chk(ADR_STATUS, 8'h00, "sweep clears complete");
  endtask : t_settle
  task automatic t_modes;
    cmd(C_PDOWN);
    chk(24'(pwr_down), 24'h1, "power-down mode");
    cmd(C_STBY);
    chk(24'(pwr_down), 24'h0, "standby mode");
  endtask : t_modes
  // main sequence after 20 cycles of reset
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    t_reset_state();
    t_regs();
    t_sweep();
    t_settle();
    t_modes();
    finish_test();
  end
  // watchdog well beyond the expected 40k cycles of traffic
  initial begin
    #800000;
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end
endmodule : imp_sweep_regs_tb
